// ==== adccfg_defines.vh ====
// constants for the converter configuration word and its serial port
`ifndef ADCCFG_DEFINES_VH
`define ADCCFG_DEFINES_VH

// ---------------------------------------------------------------
// configuration word layout
// ---------------------------------------------------------------
`define ADCCFG_RESET        16'h058b
`define ADCCFG_START_BIT    15
`define ADCCFG_MUX_HI       14
`define ADCCFG_MUX_LO       12
`define ADCCFG_FSR_HI       11
`define ADCCFG_FSR_LO       9
`define ADCCFG_MODE_BIT     8
`define ADCCFG_RATE_HI      7
`define ADCCFG_RATE_LO      5
`define ADCCFG_TEMP_BIT     4
`define ADCCFG_PULL_BIT     3
`define ADCCFG_KEY_HI       2
`define ADCCFG_KEY_LO       1
`define ADCCFG_RSVD_BIT     0
`define ADCCFG_KEY_VALID    2'h1

// ---------------------------------------------------------------
// transfer framing
// ---------------------------------------------------------------
`define ADCCFG_WORD_BITS    6'h10
`define ADCCFG_LAST_WR_BIT  6'h0f
`define ADCCFG_CNT_W        6
`define ADCCFG_BITS_32      6'h20

`endif

// ==== adccfg_config_register.v ====
// configuration word with serial write/readback and conversion sequencing
//
// How it works
// R01: start bit launches one conversion from power-down
// R02: start bit always reads back zero
// R03: bits 14:12 choose input pair
// R04: bits 11:9 choose full-scale range
// R05: bit 8 chooses continuous or single-shot
// R06: bits 7:5 choose output data rate
// R07: bit 4 selects temperature sensor input
// R08: weak pullup only when deselected and enabled
// R09: word updates only when key equals 01
// R10: reserved bit ignores writes, reads one
// R11: word resets to 058Bh
// R12: sample input on falling, shift on rising
// R13: readback of stored word in last bytes
// R14: continuous mode converts back to back always
// R15: single-shot returns to power-down after completion
`timescale 1ns/1ps
`include "adccfg_defines.vh"

module adccfg_config_register (
  // system
  input  wire        clk_sys,
  input  wire        resetn,
  // serial pins
  input  wire        sclk,
  input  wire        csn,
  input  wire        serialIn,
  output reg         serialOutReady,
  output reg         serialOutReadyOe,
  output reg         pullupEnable,
  // converter core
  input  wire [15:0] convResult,
  input  wire        convDone,
  output reg         convStart,
  output reg         convBusy,
  output reg  [2:0]  inputSelect,
  output reg  [2:0]  fullScaleRange,
  output reg         continuousMode,
  output reg  [2:0]  rateSelect,
  output reg         tempSensorSelect
);

  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam [1:0] ST_DOWN = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // -------------------------------------------------------------
  // word and frame constants
  // -------------------------------------------------------------
  localparam [15:0] RESET_WORD = `ADCCFG_RESET;
  localparam [5:0]  HALF_BITS  = `ADCCFG_WORD_BITS;
  localparam [5:0]  LAST_WRITE = `ADCCFG_LAST_WR_BIT;
  localparam [5:0]  FULL_BITS  = `ADCCFG_BITS_32;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // bit counter step, wraps after a full readback frame
  function [5:0] countStep;
    input [5:0] cnt;
    begin
      if (cnt == FULL_BITS) begin
        countStep = 6'h01;
      end else begin
        countStep = cnt + 6'h01;
      end
    end
  endfunction

  // a received word is only taken with key field 01
  function keyValid;
    input [15:0] word;
    begin
      keyValid = (word[`ADCCFG_KEY_HI:`ADCCFG_KEY_LO] == `ADCCFG_KEY_VALID);
    end
  endfunction

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  reg [1:0] sclkSync;
  reg [1:0] csnSync;
  reg [1:0] dinSync;
  reg       sclkLast;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclkSync <= 2'h0;
      csnSync  <= 2'h3;
      dinSync  <= 2'h0;
      sclkLast <= 1'b0;
    end else begin
      sclkSync <= {sclkSync[0], sclk};
      csnSync  <= {csnSync[0], csn};
      dinSync  <= {dinSync[0], serialIn};
      sclkLast <= sclkSync[1];
    end
  end

  wire sclkRise = sclkSync[1] & ~sclkLast;
  wire sclkFall = ~sclkSync[1] & sclkLast;
  wire selected = ~csnSync[1];

  // -------------------------------------------------------------
  // readback view of the stored word
  // -------------------------------------------------------------
  reg  [15:1] cfg;
  reg  [15:0] resultBuf;
  wire [15:0] cfgView = {1'b0, cfg[14:1], 1'b1}; // [R02] [R10]

  // -------------------------------------------------------------
  // serial shifting
  // -------------------------------------------------------------
  reg [5:0]  bitCount;
  reg [15:0] shiftIn;
  reg [15:0] shiftOut;
  reg        writeCommit;
  reg [15:0] writeWord;

  wire [15:0] next_shiftIn = {shiftIn[14:0], dinSync[1]};

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bitCount    <= 6'h0;
      shiftIn     <= 16'h0000;
      shiftOut    <= 16'h0000;
      writeCommit <= 1'b0;
      writeWord   <= 16'h0000;
    end else begin
      writeCommit <= 1'b0;
      if (!selected) begin
        bitCount <= 6'h0;
        shiftOut <= resultBuf;
      end else if (sclkRise) begin
        // whole fresh result at each frame head, stored word after bit 16
        if (bitCount == 6'h00 || bitCount == FULL_BITS) begin
          shiftOut <= resultBuf; // [R12]
        end else if (bitCount == HALF_BITS) begin
          shiftOut <= cfgView; // [R13]
        end else begin
          shiftOut <= {shiftOut[14:0], 1'b0}; // [R12]
        end
      end else if (sclkFall) begin
        shiftIn  <= next_shiftIn; // [R12]
        bitCount <= countStep(bitCount);
        if (bitCount == LAST_WRITE) begin
          writeCommit <= 1'b1;
          writeWord   <= next_shiftIn;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // configuration store and conversion sequencer
  // -------------------------------------------------------------
  reg [1:0] state;
  wire keyOk = keyValid(writeWord); // [R09]

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg       <= RESET_WORD[15:1]; // [R11]
      state     <= ST_DOWN;
      convStart <= 1'b0;
      resultBuf <= 16'h0000;
    end else begin
      convStart <= 1'b0;
      if (writeCommit && keyOk) begin
        cfg <= {1'b0, writeWord[14:1]}; // [R09] [R03] [R04] [R05] [R06] [R07]
      end
      if (convDone) begin
        resultBuf <= convResult;
      end
      case (state)
        ST_DOWN: begin
          if (!cfg[`ADCCFG_MODE_BIT]) begin
            convStart <= 1'b1; // [R14]
            state     <= ST_CONV;
          end else if (writeCommit && keyOk && writeWord[`ADCCFG_START_BIT]) begin
            convStart <= 1'b1; // [R01]
            state     <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (convDone) begin
            if (!cfg[`ADCCFG_MODE_BIT]) begin
              convStart <= 1'b1; // [R14]
            end else begin
              state <= ST_DOWN; // [R15]
            end
          end
        end
        default: state <= ST_DOWN;
      endcase
    end
  end

  // -------------------------------------------------------------
  // registered outputs
  // -------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serialOutReady   <= 1'b1;
      serialOutReadyOe <= 1'b0;
      pullupEnable     <= RESET_WORD[`ADCCFG_PULL_BIT];
      convBusy         <= 1'b0;
      inputSelect      <= RESET_WORD[`ADCCFG_MUX_HI:`ADCCFG_MUX_LO];
      fullScaleRange   <= RESET_WORD[`ADCCFG_FSR_HI:`ADCCFG_FSR_LO];
      continuousMode   <= ~RESET_WORD[`ADCCFG_MODE_BIT];
      rateSelect       <= RESET_WORD[`ADCCFG_RATE_HI:`ADCCFG_RATE_LO];
      tempSensorSelect <= RESET_WORD[`ADCCFG_TEMP_BIT];
    end else begin
      serialOutReady   <= shiftOut[15];
      serialOutReadyOe <= selected;
      pullupEnable     <= ~selected & cfg[`ADCCFG_PULL_BIT]; // [R08]
      convBusy         <= (state == ST_CONV);
      inputSelect      <= cfg[`ADCCFG_MUX_HI:`ADCCFG_MUX_LO]; // [R03]
      fullScaleRange   <= cfg[`ADCCFG_FSR_HI:`ADCCFG_FSR_LO]; // [R04]
      continuousMode   <= ~cfg[`ADCCFG_MODE_BIT]; // [R05]
      rateSelect       <= cfg[`ADCCFG_RATE_HI:`ADCCFG_RATE_LO]; // [R06]
      tempSensorSelect <= cfg[`ADCCFG_TEMP_BIT]; // [R07]
    end
  end

endmodule

// ==== adccfg_spi_master.sv ====
// serial master model, clock idles low between frames
`timescale 1ns/1ps
module adccfg_spi_master (
  input  wire  clk_sys,
  output logic sclk = 0,
  output logic csn  = 1,
  output logic mosi = 0,
  input  wire  miso
);
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    @(posedge clk_sys);
    #1 csn = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    for (int b = 31; b >= 0; b--) begin
      sclk = 1;
      mosi = tx[b];
      repeat (4) @(posedge clk_sys);
      #1 sclk = 0;
      repeat (4) @(posedge clk_sys);
      #1 rx[b] = miso;
      if (b == 16) begin
        repeat (520) @(posedge clk_sys);
        #1;
      end
    end
    repeat (8) @(posedge clk_sys);
    #1 csn = 1;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
endmodule

// ==== adccfg_config_register_asserts.sv ====
// port checker for the configuration register
`timescale 1ns/1ps
module adccfg_asserts (
  input wire       clk_sys, resetn, csn, serialOutReadyOe, pullupEnable, convStart, convDone, convBusy,
  input wire       continuousMode, tempSensorSelect,
  input wire [2:0] inputSelect, fullScaleRange, rateSelect
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_pull; serialOutReadyOe |-> !pullupEnable; endproperty
  a_pull: assert property (p_pull) else $error("pullup while driving");
  property p_drv; !csn [*4] |-> serialOutReadyOe; endproperty
  a_drv: assert property (p_drv) else $error("not driving when selected");
  property p_idle; csn [*4] |-> !serialOutReadyOe; endproperty
  a_idle: assert property (p_idle) else $error("driving when deselected");
  property p_one; convBusy && !continuousMode |-> !convStart; endproperty
  a_one: assert property (p_one) else $error("start while converting");
  property p_busy; convStart && !continuousMode |=> convBusy; endproperty
  a_busy: assert property (p_busy) else $error("start without busy");
  property p_end; convBusy && convDone && !continuousMode |=> ##1 !convBusy; endproperty
  a_end: assert property (p_end) else $error("no return to power-down");
  property p_cont; convDone && continuousMode |-> ##[0:1] convStart; endproperty
  a_cont: assert property (p_cont) else $error("no restart");
  property p_hold;
    csn [*6] |=> $stable({inputSelect, fullScaleRange, rateSelect, tempSensorSelect, continuousMode});
  endproperty
  a_hold: assert property (p_hold) else $error("word changed while idle");
  c_start: cover property (convStart && !continuousMode);
  c_cont: cover property (convDone && continuousMode);
  c_frame: cover property (!csn ##1 csn);
endmodule
bind adccfg_config_register adccfg_asserts i_asserts (.clk_sys, .resetn, .csn, .serialOutReadyOe, .pullupEnable,
  .convStart, .convDone, .convBusy, .continuousMode, .tempSensorSelect, .inputSelect, .fullScaleRange, .rateSelect);

// ==== adccfg_config_register_tb.sv ====
// self-checking bench for the configuration register
`timescale 1ns/1ps
module adccfg_config_register_tb;
  logic        clk_sys = 0, resetn = 0, convDone = 0, lastOut = 0;
  logic [15:0] convResult = 16'h0000, er;
  logic [31:0] rx;
  logic [31:0] rows [0:11] = '{32'h0000058b, 32'h010a010b, 32'h13331333, 32'h254a254b, 32'h37733773,
    32'h498a498b, 32'h5bb35bb3, 32'h6dca6dcb, 32'h7ff37ff3, 32'h00007ff3, 32'hfffc7ff3, 32'h00067ff3};
  wire         sclk, csn, serialIn, serialOutReady, serialOutReadyOe, pullupEnable, convStart, convBusy;
  wire         continuousMode, tempSensorSelect;
  wire [2:0]   inputSelect, fullScaleRange, rateSelect;
  int          fails = 0, cmp_count = 0, starts = 0, busyCnt = 0;
  wire         miso = serialOutReadyOe ? serialOutReady : (pullupEnable | lastOut);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (serialOutReadyOe) lastOut <= ~serialOutReady;
  // converter core stand-in
  always @(posedge clk_sys) begin
    #1 convDone = 0;
    if (convStart) begin
      starts++;
      busyCnt = 1000;
    end else if (busyCnt == 1) begin
      convDone = 1;
      convResult = convResult + 16'h1357;
    end
    if (busyCnt != 0) busyCnt--;
  end
  adccfg_config_register i_dut (.clk_sys, .resetn, .sclk, .csn, .serialIn, .serialOutReady, .serialOutReadyOe,
    .pullupEnable, .convResult, .convDone, .convStart, .convBusy, .inputSelect, .fullScaleRange,
    .continuousMode, .rateSelect, .tempSensorSelect);
  adccfg_spi_master i_mst (.clk_sys, .sclk, .csn, .mosi(serialIn), .miso);
  function automatic logic [11:0] fld();
    return {inputSelect, fullScaleRange, ~continuousMode, rateSelect, tempSensorSelect, pullupEnable};
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 resetn = 1;
    repeat (3) @(posedge clk_sys);
    for (int r = 0; r < 12; r++) begin
      er = convResult;
      i_mst.xfer({2{rows[r][31:16]}}, rx);
      check(rx[31:16], er);
      check(rx[15:0], rows[r][15:0]);
      check(fld(), rows[r][14:3]);
    end
    check(starts, 0);
    repeat (2) begin
      i_mst.xfer({2{16'h858b}}, rx);
      check(rx[15:0], 16'h058b);
    end
    check(starts, 1);
    repeat (1100) @(posedge clk_sys);
    i_mst.xfer({2{16'h858b}}, rx);
    check(starts, 2);
    check(rx[15:0], 16'h058b);
    i_mst.xfer({2{16'h048b}}, rx);
    check(rx[15:0], 16'h048b);
    repeat (3000) @(posedge clk_sys);
    check(continuousMode && starts > 3, 1);
    #1 resetn = 0;
    repeat (6) @(posedge clk_sys);
    #1 resetn = 1;
    repeat (3) @(posedge clk_sys);
    #1 check(fld(), 12'h0b1);
    i_mst.xfer(32'h00000000, rx);
    check(rx[15:0], 16'h058b);
    give_verdict;
  end
endmodule
